// ### verif/spi_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// serial host: one 16-bit word per select, sclk idles low
// ------------------------------------------------------------
module spi_host_model
(
  input wire logic ref_clk, // system clock
  output logic spi_sclk, // serial clock
  output logic spi_cs_n, // chip select, active low
  output logic spi_mosi, // data to the device
  input wire logic spi_miso, // data from the device
  input wire logic spi_miso_oe_n // low while the device drives
);
  // half period in system cycles; sync chain needs at least 2
  localparam int HALF = 5;

  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  // msb first; launch on rise, device samples on fall
  // nb below sixteen sends a cut word that the device must drop
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp,
    output logic oe_ok, input int nb = 16);
    oe_ok = 1'b1;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int i = 15; i > 15 - nb; i--)
    begin
      spi_mosi = cmd[i];
      spi_sclk = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      spi_sclk = 1'b0;
      repeat (HALF) @(negedge ref_clk);
      // answer bit stands until the next rise, so take it late
      rsp[i] = spi_miso;
      oe_ok = oe_ok & (spi_miso_oe_n === 1'b0);
    end
    spi_cs_n = 1'b1;
    // a released line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// ### verif/tb_gate_fault_config_regs.sv
`timescale 1ns/1ps
module tb_gate_fault_config_regs
  import gate_regs_pkg::*;
;
  logic ref_clk, srst, sclk, cs_n, mosi, miso, oe_n, sleep_req, gate_en;
  logic [8:0] flt; // device fault pins, top flag first
  logic [5:0] gflt, g; // gate fault pins and their last value
  logic [1:0] hpk, lpk, blank, degl;
  logic [3:0] hsk, hsr, lsk, lsr;
  pwm_mode_t mode;
  logic fw, oe_ok;
  logic [12:0] dtns;
  logic [15:0] rsp;
  logic [10:0] d;
  int n_mismatch = 0, compares = 0, cyc = 0;
  int mdl[16]; // model of every word's contents
  int dt_tab[8] = '{40, 60, 100, 500, 1000, 2000, 4000, 6000};
  logic [31:0] seed = 32'h1EB45452;

  gate_fault_config_regs dut (.ref_clk(ref_clk), .srst(srst),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe_n(oe_n), .sleep_request(sleep_req), .gate_enable(gate_en),
    .supply_undervolt_two(flt[8]), .watchdog_expired_flag(flt[7]),
    .overtemp_shutdown_flag(flt[6]), .regulator_undervolt_flag(flt[5]),
    .analog_supply_undervolt_flag(flt[4]),
    .pump_lowside_driver_flag(flt[3]),
    .pump_highside_undervolt_flag(flt[2]),
    .pump_highside_overvolt_flag(flt[1]),
    .pump_highside_abs_overvolt_flag(flt[0]), .gate_fault_in(gflt),
    .high_side_peak_time(hpk), .high_side_sink_current(hsk),
    .high_side_source_current(hsr), .low_side_peak_time(lpk),
    .low_side_sink_current(lsk), .low_side_source_current(lsr),
    .pwm_mode(mode), .freewheel_select(fw), .dead_time_ns(dtns),
    .drain_sense_blanking(blank), .drain_sense_deglitch(degl));

  spi_host_model host (.ref_clk(ref_clk), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe_n(oe_n));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // hang guard: about 1.6 times the expected run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // reserved bits 7 and 3 always read zero
  function automatic int fword(logic [8:0] f);
    return {f[8:6], 1'b0, f[5:3], 1'b0, f[2:0]};
  endfunction

  task automatic rd(logic [3:0] a);
    host.xfer({1'b1, a, 11'h000}, rsp, oe_ok);
    check("read data", {5'h00, rsp[10:0]}, 16'(mdl[a]));
    check("miso enable", 16'(oe_ok), 16'h0001);
    check("miso idle", 16'(oe_n), 16'h0001);
  endtask

  // answer to a write is the old contents
  task automatic wr(logic [3:0] a, logic [10:0] v);
    host.xfer({1'b0, a, v}, rsp, oe_ok);
    check("write echo", {5'h00, rsp[10:0]}, 16'(mdl[a]));
    if (a >= 4'h5 && a <= 4'h7)
      mdl[a] = v & 11'h3FF;
    if (a == 4'h9 && v[1])
    begin
      mdl[3] = 0;
      mdl[4] = 0;
    end
  endtask

  // decoded control outputs against the model words
  task automatic outs();
    int m, pm;
    m = (mdl[7] >> 7) & 3;
    pm = int'(PWM_SIX_INPUTS);
    if (m == 1)
      pm = int'(PWM_THREE_INPUTS);
    if (m == 2)
      pm = int'(PWM_SINGLE_INPUT);
    repeat (3) @(negedge ref_clk);
    check("hs peak", 16'(hpk), 16'(mdl[5] >> 8));
    check("hs sink", 16'(hsk), 16'((mdl[5] >> 4) & 15));
    check("hs source", 16'(hsr), 16'(mdl[5] & 15));
    check("ls peak", 16'(lpk), 16'(mdl[6] >> 8));
    check("ls sink", 16'(lsk), 16'((mdl[6] >> 4) & 15));
    check("ls source", 16'(lsr), 16'(mdl[6] & 15));
    check("pwm mode", 16'(mode), 16'(pm));
    check("freewheel", 16'(fw), 16'(((mdl[7] >> 9) & 1) && m == 2));
    check("dead time", 16'(dtns), 16'(dt_tab[(mdl[7] >> 4) & 7]));
    check("blanking", 16'(blank), 16'((mdl[7] >> 2) & 3));
    check("deglitch", 16'(degl), 16'(mdl[7] & 3));
  endtask

  task automatic ctrl_rd();
    for (int a = 5; a <= 7; a++)
      rd(4'(a));
    outs();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    sleep_req = 1'b0;
    gate_en = 1'b1;
    flt = 9'h000;
    gflt = 6'h00;
    mdl = '{default: 0};
    mdl[5] = 'h344;
    mdl[6] = 'h344;
    mdl[7] = 'h216;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    for (int a = 3; a <= 9; a++)
      rd(4'(a));
    outs();
    $display("test defaults done");
    // every dead time code and every mode, other bits random
    for (int i = 0; i < 8; i++)
    begin
      d = 11'(xs());
      d[6:4] = 3'(i);
      d[8:7] = 2'(i);
      wr(4'h7, d);
      wr(4'h5, 11'(xs()));
      wr(4'h6, 11'(xs()));
      ctrl_rd();
    end
    $display("test control words done");
    gate_en = 1'b0;
    repeat (6) @(negedge ref_clk);
    gate_en = 1'b1;
    ctrl_rd();
    sleep_req = 1'b1;
    repeat (6) @(negedge ref_clk);
    sleep_req = 1'b0;
    repeat (6) @(negedge ref_clk);
    mdl[5] = 'h344;
    mdl[6] = 'h344;
    mdl[7] = 'h216;
    ctrl_rd();
    // a cut word must not write; then a mid-run reset restores defaults
    host.xfer({1'b0, 4'h5, 11'h0AA}, rsp, oe_ok, 15);
    rd(4'h5);
    wr(4'h6, 11'(xs()));
    srst = 1'b1;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    mdl[6] = 'h344;
    ctrl_rd();
    $display("test sleep and gate enable done");
    // each device flag alone with random gate flags, sticky after the pin drops
    for (int i = 0; i < 9; i++)
    begin
      g = 6'(xs());
      flt = 9'h001 << i;
      gflt = g;
      repeat (6) @(negedge ref_clk);
      flt = 9'h000;
      gflt = 6'h00;
      repeat (6) @(negedge ref_clk);
      mdl[3] = fword(9'h001 << i);
      mdl[4] = {g, 5'h00};
      rd(4'h3);
      rd(4'h4);
      wr(4'h3, 11'h7FF);
      wr(4'h4, 11'h7FF);
      rd(4'h3);
      wr(4'h9, 11'h002);
      rd(4'h3);
      rd(4'h4);
    end
    flt = 9'h1FF;
    gflt = 6'h3F;
    repeat (6) @(negedge ref_clk);
    flt = 9'h000;
    gflt = 6'h00;
    repeat (6) @(negedge ref_clk);
    mdl[3] = fword(9'h1FF);
    mdl[4] = 'h7E0;
    rd(4'h3);
    rd(4'h4);
    gate_en = 1'b0;
    repeat (6) @(negedge ref_clk);
    gate_en = 1'b1;
    mdl[3] = 0;
    mdl[4] = 0;
    rd(4'h3);
    rd(4'h4);
    $display("test fault words done");
    summarize();
  end
endmodule

// ### verilog/bridge_setup_decode.sv
`timescale 1ns/1ps
`include "gate_regs_consts.svh"
// turns the bridge timing word into the settings the bridge uses
module bridge_setup_decode
  import gate_regs_pkg::*;
(
  input wire logic [10:0] setup_word, // bridge timing word
  output pwm_mode_t pwm_mode, // decoded input arrangement
  output logic active_freewheel, // effective freewheel choice
  output logic [`DEAD_NS_W-1:0] dead_time_ns // dead time in ns
);

  // dead time lookup, indexed by the 3-bit code
  localparam logic [7:0][`DEAD_NS_W-1:0] DEAD_TABLE = `DEAD_NS_TABLE;

  logic [1:0] mode_code; // raw mode field

  assign mode_code = setup_word[`MODE_MSB:`MODE_LSB];
  assign dead_time_ns = DEAD_TABLE[setup_word[`DEAD_MSB:`DEAD_LSB]];

  // ----------------------------------------------------------------
  // mode decode; code 11 falls back to six inputs
  // ----------------------------------------------------------------
  always_comb
  begin
    case (mode_code)
      `MODE_THREE_CODE: pwm_mode = PWM_THREE_INPUTS;
      `MODE_SINGLE_CODE: pwm_mode = PWM_SINGLE_INPUT;
      default: pwm_mode = PWM_SIX_INPUTS;
    endcase
  end

  // freewheel bit only matters in single-input operation
  assign active_freewheel = (mode_code == `MODE_SINGLE_CODE) &&
    setup_word[`FREEWHEEL_BIT];

endmodule

// ### verilog/gate_fault_config_regs.sv
`timescale 1ns/1ps
`include "gate_regs_consts.svh"
// Summary of operation
// - fault word: supply, watchdog, temperature, regulator flags
// - fault word: charge pump flags, bit 3 zero
// - gate-voltage word: six transistor flags, bits 10:5
// - reads and gate-enable reset keep control words
// - power-up loads control word defaults
// - sleep entry restores control word defaults
// - high-side peak time bits 9:8, default 11
// - high-side sink current bits 7:4, default 0100
// - high-side source current bits 3:0, default 0100
// - low-side peak time bits 9:8, default 11
// - low-side sink current bits 7:4, default 0100
// - low-side source current bits 3:0, default 0100
// - pwm mode bits 8:7: six, three, single inputs
// - freewheel bit 9 acts only in single mode
// - dead time bits 6:4, default 001
// - drain sense blanking bits 3:2, default 01
// - drain sense deglitch bits 1:0, default 10
// - 16-bit word: direction, address, eleven data
// - flag 0 writes, 1 reads; data returned
// - writing clear bit wipes latched faults
module gate_fault_config_regs
  import gate_regs_pkg::*;
(
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic srst, // power-up reset, active high
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_cs_n, // chip select pin, active low
  input wire logic spi_mosi, // serial data in pin
  output logic spi_miso, // serial data out
  output logic spi_miso_oe_n, // low while data out is driven
  input wire logic sleep_request, // high while device asleep
  input wire logic gate_enable, // gate enable pin
  input wire logic supply_undervolt_two, // supply undervoltage 2
  input wire logic watchdog_expired_flag, // watchdog fault
  input wire logic overtemp_shutdown_flag, // overtemperature
  input wire logic regulator_undervolt_flag, // regulator undervoltage
  input wire logic analog_supply_undervolt_flag, // analog supply uv
  input wire logic pump_lowside_driver_flag, // pump low-side fault
  input wire logic pump_highside_undervolt_flag, // pump high-side uv
  input wire logic pump_highside_overvolt_flag, // pump high-side ov
  input wire logic pump_highside_abs_overvolt_flag, // pump abs ov
  input wire logic [5:0] gate_fault_in, // high a..low c, msb first
  output logic [1:0] high_side_peak_time, // peak drive time code
  output logic [3:0] high_side_sink_current, // sink current code
  output logic [3:0] high_side_source_current, // source current code
  output logic [1:0] low_side_peak_time, // peak drive time code
  output logic [3:0] low_side_sink_current, // sink current code
  output logic [3:0] low_side_source_current, // source current code
  output pwm_mode_t pwm_mode, // decoded input arrangement
  output logic freewheel_select, // active freewheel in effect
  output logic [`DEAD_NS_W-1:0] dead_time_ns, // dead time in ns
  output logic [1:0] drain_sense_blanking, // blanking code
  output logic [1:0] drain_sense_deglitch // deglitch code
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  localparam int SYNC_W = 20;
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'h80000; // select idle

  logic [SYNC_W-1:0] pins_raw; // gathered raw pins
  logic [SYNC_W-1:0] pins_s; // synchronised pins
  logic cs_n_s, sclk_s, mosi_s, sleep_s, gate_en_s; // link levels
  logic [8:0] dev_flags_s; // device fault levels
  logic [5:0] gate_flags_s; // gate-voltage fault levels

  assign pins_raw = {spi_cs_n, spi_sclk, spi_mosi, sleep_request,
    gate_enable, supply_undervolt_two, watchdog_expired_flag,
    overtemp_shutdown_flag, regulator_undervolt_flag,
    analog_supply_undervolt_flag, pump_lowside_driver_flag,
    pump_highside_undervolt_flag, pump_highside_overvolt_flag,
    pump_highside_abs_overvolt_flag, gate_fault_in};

  pin_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign {cs_n_s, sclk_s, mosi_s, sleep_s, gate_en_s, dev_flags_s,
    gate_flags_s} = pins_s;

  // ----------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------
  logic cs_prev_q, sclk_prev_q, sleep_prev_q, gate_en_prev_q;
  logic cs_fall, cs_rise, sclk_fall, sclk_rise; // link events
  logic sleep_rise, gate_en_fall; // mode events

  // previous levels, reset to idle so no false edge appears
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      sleep_prev_q <= 1'b0;
      gate_en_prev_q <= 1'b0;
    end
    else
    begin
      cs_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
      sleep_prev_q <= sleep_s;
      gate_en_prev_q <= gate_en_s;
    end
  end

  assign cs_fall = cs_prev_q && !cs_n_s;
  assign cs_rise = !cs_prev_q && cs_n_s;
  assign sclk_fall = sclk_prev_q && !sclk_s;
  assign sclk_rise = !sclk_prev_q && sclk_s;
  assign sleep_rise = !sleep_prev_q && sleep_s;
  assign gate_en_fall = gate_en_prev_q && !gate_en_s;

  // ----------------------------------------------------------------
  // serial word sequencer
  // ----------------------------------------------------------------
  spi_state_t state_q; // idle or inside a word
  logic [4:0] bit_cnt_q; // bits sampled so far
  logic [15:0] in_sh_q; // incoming word, msb first
  logic [10:0] out_sh_q; // outgoing data bits
  logic [10:0] hs_q, ls_q, bridge_q; // control words
  logic [10:0] dev_q, gate_q; // latched status words
  logic [10:0] read_word; // addressed register contents
  logic [3:0] early_addr; // address once the header is in
  logic word_done, wr_commit, rd_commit, clear_evt; // word events
  logic [3:0] addr; // address of the finished word
  logic [10:0] wdata; // data of the finished word

  assign early_addr = {in_sh_q[2:0], mosi_s};

  // read mux; unmapped addresses answer zero
  always_comb
  begin
    case (early_addr)
      `ADDR_DEV_FAULT: read_word = dev_q;
      `ADDR_GATE_FAULT: read_word = gate_q;
      `ADDR_HS_DRIVE: read_word = hs_q;
      `ADDR_LS_DRIVE: read_word = ls_q;
      `ADDR_BRIDGE: read_word = bridge_q;
      default: read_word = `STATUS_RESET;
    endcase
  end

  // a word counts only when at least sixteen bits were clocked; clocks past sixteen are not counted
  assign word_done = (state_q == ST_SHIFT) && cs_rise &&
    (bit_cnt_q == `WORD_BITS);
  assign addr = in_sh_q[`ADDR_MSB:`ADDR_LSB];
  assign wdata = in_sh_q[`DATA_MSB:0];
  assign wr_commit = word_done && !in_sh_q[`RW_BIT];
  assign rd_commit = word_done && in_sh_q[`RW_BIT];
  assign clear_evt = (wr_commit && (addr == `ADDR_OPERATION) &&
    wdata[`CLEAR_FAULTS_BIT]) || gate_en_fall;

  // state and bit counter
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cs_fall)
          begin
            state_q <= ST_SHIFT;
            bit_cnt_q <= 5'h00;
          end
        ST_SHIFT:
          if (cs_rise)
            state_q <= ST_IDLE;
          else if (sclk_fall && (bit_cnt_q != `WORD_BITS))
            bit_cnt_q <= bit_cnt_q + 5'h01; // extra clocks are ignored
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // sample data in on the falling serial clock
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      in_sh_q <= 16'h0000;
    else if ((state_q == ST_SHIFT) && sclk_fall &&
      (bit_cnt_q != `WORD_BITS))
      in_sh_q <= {in_sh_q[14:0], mosi_s};
  end

  // load answer once the address is known, launch on rising clock
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_sh_q <= 11'h000;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end
    else if (state_q == ST_IDLE)
    begin
      spi_miso <= 1'b0; // header bits go out as zero
      spi_miso_oe_n <= !cs_fall;
    end
    else if (cs_rise)
      spi_miso_oe_n <= 1'b1;
    else if (sclk_fall && (bit_cnt_q == (`HDR_BITS - 5'h01)))
      out_sh_q <= read_word;
    else if (sclk_rise && (bit_cnt_q >= `HDR_BITS) &&
      (bit_cnt_q != `WORD_BITS))
    begin
      spi_miso <= out_sh_q[10];
      out_sh_q <= {out_sh_q[9:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // control words
  // ----------------------------------------------------------------
  // reads and gate-enable resets never reach here
  always_ff @(posedge ref_clk)
  begin
    if (srst || sleep_rise)
    begin
      hs_q <= `HS_DRIVE_DEFAULT;
      ls_q <= `LS_DRIVE_DEFAULT;
      bridge_q <= `BRIDGE_DEFAULT;
    end
    else if (wr_commit)
    begin
      case (addr)
        `ADDR_HS_DRIVE: hs_q <= wdata & `CTRL_WMASK;
        `ADDR_LS_DRIVE: ls_q <= wdata & `CTRL_WMASK;
        `ADDR_BRIDGE: bridge_q <= wdata & `CTRL_WMASK;
        default: ; // status words and others: ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // latched status; a new fault wins over a clear in the same cycle
  // ----------------------------------------------------------------
  logic [10:0] dev_set, gate_set, clr_mask; // set and clear terms

  assign dev_set = {dev_flags_s[8:6], 1'b0, dev_flags_s[5:3], 1'b0,
    dev_flags_s[2:0]} & `DEV_FAULT_MASK;
  assign gate_set = {gate_flags_s, 5'h00} & `GATE_FAULT_MASK;
  assign clr_mask = {11{clear_evt}};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      dev_q <= `STATUS_RESET;
      gate_q <= `STATUS_RESET;
    end
    else
    begin
      dev_q <= (dev_q & ~clr_mask) | dev_set;
      gate_q <= (gate_q & ~clr_mask) | gate_set;
    end
  end

  // ----------------------------------------------------------------
  // setting outputs, all registered
  // ----------------------------------------------------------------
  pwm_mode_t mode_d; // decoded mode
  logic freewheel_d; // effective freewheel
  logic [`DEAD_NS_W-1:0] dead_d; // decoded dead time

  bridge_setup_decode u_decode (
    .setup_word(bridge_q),
    .pwm_mode(mode_d),
    .active_freewheel(freewheel_d),
    .dead_time_ns(dead_d)
  );

  // one cycle behind the words; harmless for slow setup changes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pwm_mode <= PWM_SIX_INPUTS;
      freewheel_select <= 1'b0;
      dead_time_ns <= '0;
    end
    else
    begin
      pwm_mode <= mode_d;
      freewheel_select <= freewheel_d;
      dead_time_ns <= dead_d;
    end
  end

  assign high_side_peak_time = hs_q[`PEAK_MSB:`PEAK_LSB];
  assign high_side_sink_current = hs_q[`SINK_MSB:`SINK_LSB];
  assign high_side_source_current = hs_q[`SOURCE_MSB:`SOURCE_LSB];
  assign low_side_peak_time = ls_q[`PEAK_MSB:`PEAK_LSB];
  assign low_side_sink_current = ls_q[`SINK_MSB:`SINK_LSB];
  assign low_side_source_current = ls_q[`SOURCE_MSB:`SOURCE_LSB];
  assign drain_sense_blanking = bridge_q[`BLANK_MSB:`BLANK_LSB];
  assign drain_sense_deglitch =
    bridge_q[`DEGLITCH_MSB:`DEGLITCH_LSB];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_powerup_defaults: assert property (
    @(posedge ref_clk) $fell(srst) |-> (hs_q == `HS_DRIVE_DEFAULT) &&
    (ls_q == `LS_DRIVE_DEFAULT) && (bridge_q == `BRIDGE_DEFAULT))
    else $error("control words not at defaults after reset");
  a_sleep_defaults: assert property (
    sleep_rise |=> (hs_q == `HS_DRIVE_DEFAULT) &&
    (bridge_q == `BRIDGE_DEFAULT) && (ls_q == `LS_DRIVE_DEFAULT))
    else $error("sleep entry did not restore defaults");
  a_read_keeps_ctrl: assert property (
    (rd_commit || gate_en_fall) && !sleep_rise && !wr_commit |=>
    $stable(hs_q) && $stable(ls_q) && $stable(bridge_q))
    else $error("control word changed on read or gate reset");
  a_write_lands: assert property (
    wr_commit && (addr == `ADDR_BRIDGE) && !sleep_rise |=>
    bridge_q == ($past(wdata) & `CTRL_WMASK))
    else $error("write to bridge word lost");
  a_reserved_zero: assert property (
    (hs_q[10] == 1'b0) && (ls_q[10] == 1'b0) && (bridge_q[10] == 1'b0)
    && ((dev_q & ~`DEV_FAULT_MASK) == 11'h000) && (gate_q[4:0] == 5'h00))
    else $error("reserved bit set");
  a_fault_latches: assert property (
    dev_flags_s[8] ##1 !dev_flags_s[8] && !clear_evt |-> dev_q[10])
    else $error("supply fault not held");
  a_gate_flag_set: assert property (
    gate_flags_s[5] |=> gate_q[10])
    else $error("gate fault high a not latched");
  a_clear_faults: assert property (
    clear_evt && (dev_set == 11'h000) && (gate_set == 11'h000) |=>
    (dev_q == `STATUS_RESET) && (gate_q == `STATUS_RESET))
    else $error("clear did not wipe status");
  a_freewheel_mode: assert property (
    freewheel_select |-> pwm_mode == PWM_SINGLE_INPUT)
    else $error("freewheel active outside single-input mode");
  a_answer_launch: assert property (
    (state_q == ST_SHIFT) && sclk_rise && (bit_cnt_q == `HDR_BITS) &&
    !cs_rise |=> spi_miso == $past(out_sh_q[10]))
    else $error("first data bit not launched");

  c_write_word: cover property (wr_commit);
  c_read_word: cover property (rd_commit);
  c_sleep_entry: cover property (sleep_rise);
  c_fault_clear: cover property (clear_evt && (dev_q != 11'h000));

endmodule

// ### verilog/gate_regs_consts.svh
`ifndef GATE_REGS_CONSTS_SVH
`define GATE_REGS_CONSTS_SVH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define WORD_BITS 5'h10
`define HDR_BITS 5'h05
`define RW_BIT 15
`define ADDR_MSB 14
`define ADDR_LSB 11
`define DATA_MSB 10

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_DEV_FAULT 4'h3
`define ADDR_GATE_FAULT 4'h4
`define ADDR_HS_DRIVE 4'h5
`define ADDR_LS_DRIVE 4'h6
`define ADDR_BRIDGE 4'h7
`define ADDR_OPERATION 4'h9

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define STATUS_RESET 11'h000
`define HS_DRIVE_DEFAULT 11'h344
`define LS_DRIVE_DEFAULT 11'h344
`define BRIDGE_DEFAULT 11'h216
`define CTRL_WMASK 11'h3FF
`define DEV_FAULT_MASK 11'h777
`define GATE_FAULT_MASK 11'h7E0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PEAK_MSB 9
`define PEAK_LSB 8
`define SINK_MSB 7
`define SINK_LSB 4
`define SOURCE_MSB 3
`define SOURCE_LSB 0
`define CLEAR_FAULTS_BIT 1
`define FREEWHEEL_BIT 9
`define MODE_MSB 8
`define MODE_LSB 7
`define DEAD_MSB 6
`define DEAD_LSB 4
`define BLANK_MSB 3
`define BLANK_LSB 2
`define DEGLITCH_MSB 1
`define DEGLITCH_LSB 0

// ----------------------------------------------------------------
// codes and decoded values
// ----------------------------------------------------------------
`define MODE_THREE_CODE 2'h1
`define MODE_SINGLE_CODE 2'h2
`define DEAD_NS_W 13
`define DEAD_NS_TABLE {13'h1770, 13'h0FA0, 13'h07D0, 13'h03E8, \
  13'h01F4, 13'h0064, 13'h003C, 13'h0028}

`endif

// ### verilog/gate_regs_pkg.sv
package gate_regs_pkg;

  // serial access sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } spi_state_t;

  // decoded pwm input arrangement
  typedef enum logic [1:0] {
    PWM_SIX_INPUTS,
    PWM_THREE_INPUTS,
    PWM_SINGLE_INPUT
  } pwm_mode_t;

endpackage

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser, one chain per bit
module pin_sync
  import gate_regs_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic ref_clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [WIDTH-1:0] async_in, // raw pins
  output logic [WIDTH-1:0] sync_out // synchronised levels
);

  // ----------------------------------------------------------------
  // per-bit chain
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q; // first stage, read only by the second
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          meta_q <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end
        else
        begin
          meta_q <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule
